/* File: shared/reader_bits_pkg.sv */
// constants for the reader control, acknowledge and status bit bank
package reader_bits_pkg;
  // function codes
  localparam logic [7:0] FC_READ_INPUTS = 8'h02;
  localparam logic [7:0] FC_READ_HOLDING = 8'h03;
  localparam logic [7:0] FC_READ_INPUT_REGS = 8'h04;
  localparam logic [7:0] FC_WRITE_COIL = 8'h05;
  localparam logic [7:0] FC_WRITE_REG = 8'h06;
  // exception answers
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_FUNCTION = 8'h01;
  localparam logic [7:0] EXC_ADDRESS = 8'h02;
  localparam logic [7:0] EXC_VALUE = 8'h03;
  // coil values
  localparam logic [15:0] COIL_ON = 16'hFF00;
  localparam logic [15:0] COIL_OFF = 16'h0000;
  // register, coil and discrete input numbers
  localparam logic [15:0] CONTROL_REQUEST_WORD = 16'h0001;
  localparam logic [15:0] REQUEST_ACKNOWLEDGE_WORD = 16'h03E9;
  localparam logic [15:0] READER_STATUS_WORD = 16'h03EA;
  localparam logic [15:0] INREG_ACK = 16'h0001;
  localparam logic [15:0] INREG_STATUS = 16'h0002;
  localparam logic [15:0] COIL_FIRST = 16'h0001;
  localparam logic [15:0] COIL_LAST = 16'h0010;
  localparam logic [15:0] DIN_ACK_FIRST = 16'h0001;
  localparam logic [15:0] DIN_STATUS_FIRST = 16'h0011;
  localparam logic [15:0] DIN_LAST = 16'h0020;
  // message array words
  localparam logic [7:0] MSG_W_CONTROL = 8'h00;
  localparam logic [7:0] MSG_W_PRODUCT_LO = 8'h01;
  localparam logic [7:0] MSG_W_PRODUCT_HI = 8'h02;
  localparam logic [7:0] MSG_R_ACK = 8'h00;
  localparam logic [7:0] MSG_R_STATUS = 8'h01;
  localparam logic [7:0] MSG_R_ERROR_LO = 8'h02;
  localparam logic [7:0] MSG_R_ERROR_HI = 8'h03;
  // control bit positions
  localparam int BIT_PRODUCT = 0;
  localparam int BIT_LEARN = 1;
  localparam int BIT_TRIGGER = 2;
  localparam int BIT_WINDOW = 3;
  localparam int BIT_TEXT = 5;
  localparam int BIT_MASK = 6;
  localparam int BIT_COMMAND = 15;
  localparam logic [15:0] CONTROL_DEFINED = 16'h806F;
  // status bit positions
  localparam int ST_READY = 0;
  localparam int ST_VERDICT = 1;
  localparam int ST_DECODED = 2;
  localparam int ST_READY_LATCH = 3;
  localparam int ST_OUT1 = 5;
  localparam int ST_OUT2 = 6;
  localparam int ST_OUT3 = 7;
  localparam int ST_OVERRUN = 12;
  localparam int ST_LEARN_FAULT = 13;
  localparam int ST_SYSTEM_FAULT = 14;
  localparam int ST_COMMAND_FAULT = 15;
  // reset values
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [31:0] PRODUCT_RESET = 32'h0000_0000;
endpackage

/* File: src/request_handshake.sv */
// one request bit: edge detect, action pulse and acknowledge
`timescale 1ns/1ps
module request_handshake (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic request,
  output logic ack,
  output logic action
);
  logic seen;
  logic next_seen;
  logic next_ack;
  logic next_action;

  always_comb begin
    next_seen = request;
    next_action = request & ~seen;
    // ack follows a fresh request, drops once the request is gone
    if (!request) begin
      next_ack = 1'b0;
    end else if (!seen) begin
      next_ack = 1'b1;
    end else begin
      next_ack = ack;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seen <= 1'b0;
      ack <= 1'b0;
      action <= 1'b0;
    end else begin
      seen <= next_seen;
      ack <= next_ack;
      action <= next_action;
    end
  end
endmodule // request_handshake

/* File: src/reader_bit_bank.sv */
// control, acknowledge and status bit bank with modbus and message access
`timescale 1ns/1ps
module reader_bit_bank
  import reader_bits_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic mb_valid,
  input wire logic [7:0] mb_func,
  input wire logic [15:0] mb_addr,
  input wire logic [15:0] mb_wdata,
  output logic mb_rsp_valid,
  output logic [15:0] mb_rsp_data,
  output logic [7:0] mb_rsp_exception,
  input wire logic msg_valid,
  input wire logic msg_write,
  input wire logic [7:0] msg_word,
  input wire logic [15:0] msg_wdata,
  output logic msg_rsp_valid,
  output logic [15:0] msg_rdata,
  input wire logic ready,
  input wire logic verdict_pass,
  input wire logic code_decoded,
  input wire logic [2:0] discrete_out,
  input wire logic trigger_overrun,
  input wire logic learn_fault,
  input wire logic system_fault,
  input wire logic command_fault,
  input wire logic [31:0] error_code,
  output logic [15:0] action_pulse,
  output logic [31:0] product_number
);
  // ==========================================================
  // reset release
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ==========================================================
  // control word and request handshakes
  logic [15:0] control;
  logic [15:0] ack;
  logic [15:0] status;
  logic ready_latch;

  for (genvar i = 0; i < 16; i++) begin : g_bit
    if (CONTROL_DEFINED[i]) begin : g_used
      request_handshake u_hs (
        .clk(clk),
        .rst_n(rst_n),
        .request(control[i]),
        .ack(ack[i]),
        .action(action_pulse[i])
      );
    end else begin : g_resv
      // reserved positions never acknowledge
      assign ack[i] = 1'b0;
      assign action_pulse[i] = 1'b0;
    end
  end

  // ==========================================================
  // status word
  always_comb begin
    status = 16'h0000;
    status[ST_READY] = ready;
    status[ST_VERDICT] = verdict_pass;
    status[ST_DECODED] = code_decoded;
    status[ST_READY_LATCH] = ready_latch;
    status[ST_OUT1] = discrete_out[0];
    status[ST_OUT2] = discrete_out[1];
    status[ST_OUT3] = discrete_out[2];
    status[ST_OVERRUN] = trigger_overrun;
    status[ST_LEARN_FAULT] = learn_fault;
    status[ST_SYSTEM_FAULT] = system_fault;
    status[ST_COMMAND_FAULT] = command_fault;
  end

  // ==========================================================
  // modbus access
  logic [15:0] next_control;
  logic [31:0] next_product;
  logic next_ready_latch;
  logic next_mb_rsp_valid;
  logic [15:0] next_mb_rsp_data;
  logic [7:0] next_mb_rsp_exception;
  logic next_msg_rsp_valid;
  logic [15:0] next_msg_rdata;
  logic [31:0] din_all;
  logic [15:0] coil_idx;
  logic [15:0] din_idx;
  logic mb_writes;

  assign din_all = {status, ack};
  assign coil_idx = mb_addr - COIL_FIRST;
  assign din_idx = mb_addr - DIN_ACK_FIRST;

  always_comb begin
    next_control = control;
    next_mb_rsp_valid = mb_valid;
    next_mb_rsp_data = 16'h0000;
    next_mb_rsp_exception = EXC_NONE;
    mb_writes = 1'b0;
    if (mb_valid) begin
      case (mb_func)
        FC_WRITE_REG: begin
          if (mb_addr == CONTROL_REQUEST_WORD) begin
            next_control = mb_wdata;
            next_mb_rsp_data = mb_wdata;
            mb_writes = 1'b1;
          end else begin
            next_mb_rsp_exception = EXC_ADDRESS;
          end
        end
        FC_WRITE_COIL: begin
          if (mb_addr < COIL_FIRST || mb_addr > COIL_LAST) begin
            next_mb_rsp_exception = EXC_ADDRESS;
          end else if (mb_wdata != COIL_ON && mb_wdata != COIL_OFF) begin
            next_mb_rsp_exception = EXC_VALUE;
          end else begin
            next_control[coil_idx[3:0]] = (mb_wdata == COIL_ON);
            next_mb_rsp_data = mb_wdata;
            mb_writes = 1'b1;
          end
        end
        FC_READ_HOLDING: begin
          if (mb_addr == CONTROL_REQUEST_WORD) begin
            next_mb_rsp_data = control;
          end else if (mb_addr == REQUEST_ACKNOWLEDGE_WORD) begin
            next_mb_rsp_data = ack;
          end else if (mb_addr == READER_STATUS_WORD) begin
            next_mb_rsp_data = status;
          end else begin
            next_mb_rsp_exception = EXC_ADDRESS;
          end
        end
        FC_READ_INPUT_REGS: begin
          if (mb_addr == INREG_ACK) begin
            next_mb_rsp_data = ack;
          end else if (mb_addr == INREG_STATUS) begin
            next_mb_rsp_data = status;
          end else begin
            next_mb_rsp_exception = EXC_ADDRESS;
          end
        end
        FC_READ_INPUTS: begin
          if (mb_addr < DIN_ACK_FIRST || mb_addr > DIN_LAST) begin
            next_mb_rsp_exception = EXC_ADDRESS;
          end else begin
            next_mb_rsp_data = {15'h0000, din_all[din_idx[4:0]]};
          end
        end
        default: next_mb_rsp_exception = EXC_FUNCTION;
      endcase
    end
    if (msg_valid && msg_write && msg_word == MSG_W_CONTROL && !mb_writes) begin
      next_control = msg_wdata;
    end
  end

  // ==========================================================
  // explicit message arrays; a modbus write in the same cycle wins the control word
  always_comb begin
    next_product = product_number;
    next_msg_rsp_valid = msg_valid;
    next_msg_rdata = 16'h0000;
    if (msg_valid && msg_write) begin
      if (msg_word == MSG_W_PRODUCT_LO) begin
        next_product[15:0] = msg_wdata;
      end else if (msg_word == MSG_W_PRODUCT_HI) begin
        next_product[31:16] = msg_wdata;
      end
      next_msg_rdata = msg_wdata;
    end else if (msg_valid) begin
      if (msg_word == MSG_R_ACK) begin
        next_msg_rdata = ack;
      end else if (msg_word == MSG_R_STATUS) begin
        next_msg_rdata = status;
      end else if (msg_word == MSG_R_ERROR_LO) begin
        next_msg_rdata = error_code[15:0];
      end else if (msg_word == MSG_R_ERROR_HI) begin
        next_msg_rdata = error_code[31:16];
      end
    end
  end

  // sticky ready: a new trigger clears it, a ready in the same cycle keeps it set
  always_comb begin
    next_ready_latch = ready_latch;
    if (action_pulse[BIT_TRIGGER]) begin
      next_ready_latch = 1'b0;
    end
    if (ready) begin
      next_ready_latch = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      control <= CONTROL_RESET;
      product_number <= PRODUCT_RESET;
      ready_latch <= 1'b0;
      mb_rsp_valid <= 1'b0;
      mb_rsp_data <= 16'h0000;
      mb_rsp_exception <= EXC_NONE;
      msg_rsp_valid <= 1'b0;
      msg_rdata <= 16'h0000;
    end else begin
      control <= next_control;
      product_number <= next_product;
      ready_latch <= next_ready_latch;
      mb_rsp_valid <= next_mb_rsp_valid;
      mb_rsp_data <= next_mb_rsp_data;
      mb_rsp_exception <= next_mb_rsp_exception;
      msg_rsp_valid <= next_msg_rsp_valid;
      msg_rdata <= next_msg_rdata;
    end
  end

  // ==========================================================
  // assertions
  property p_reg_write;
    @(posedge clk) disable iff (!rst_n)
    (mb_valid && mb_func == FC_WRITE_REG && mb_addr == CONTROL_REQUEST_WORD)
      |=> (control == $past(mb_wdata) && mb_rsp_valid && mb_rsp_exception == EXC_NONE);
  endproperty
  a_reg_write: assert property (p_reg_write) else $error("control word write lost");

  property p_coil_write;
    @(posedge clk) disable iff (!rst_n)
    (mb_valid && mb_func == FC_WRITE_COIL && mb_addr >= COIL_FIRST && mb_addr <= COIL_LAST
      && mb_wdata == COIL_ON) |=> control[$past(coil_idx[3:0])];
  endproperty
  a_coil_write: assert property (p_coil_write) else $error("coil write did not set its bit");

  property p_ack_rise;
    @(posedge clk) disable iff (!rst_n)
    $rose(control[BIT_TRIGGER]) |=> ack[BIT_TRIGGER] ##0 action_pulse[BIT_TRIGGER] ##1
      !action_pulse[BIT_TRIGGER];
  endproperty
  a_ack_rise: assert property (p_ack_rise) else $error("trigger not acknowledged");

  property p_ack_clear;
    @(posedge clk) disable iff (!rst_n)
    !control[BIT_COMMAND] |=> !ack[BIT_COMMAND];
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("command ack stuck high");

  property p_ack_reserved;
    @(posedge clk) disable iff (!rst_n)
    (ack & ~CONTROL_DEFINED) == 16'h0000 && (ack & ~$past(control)) == 16'h0000;
  endproperty
  a_ack_reserved: assert property (p_ack_reserved) else $error("ack without request");

  property p_ack_read;
    @(posedge clk) disable iff (!rst_n)
    (mb_valid && mb_func == FC_READ_INPUT_REGS && mb_addr == INREG_ACK)
      |=> mb_rsp_data == $past(ack);
  endproperty
  a_ack_read: assert property (p_ack_read) else $error("ack register read wrong");

  property p_din_read;
    @(posedge clk) disable iff (!rst_n)
    (mb_valid && mb_func == FC_READ_INPUTS && mb_addr == 16'h0001)
      |=> mb_rsp_data == {15'h0000, $past(ack[0])};
  endproperty
  a_din_read: assert property (p_din_read) else $error("discrete input 1 wrong");

  property p_status_read;
    @(posedge clk) disable iff (!rst_n)
    (mb_valid && mb_func == FC_READ_HOLDING && mb_addr == READER_STATUS_WORD)
      |=> (mb_rsp_data == $past(status) && mb_rsp_data[4] == 1'b0 && mb_rsp_data[11:8] == 4'h0);
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong");

  property p_status_bits;
    @(posedge clk) disable iff (!rst_n)
    (mb_valid && mb_func == FC_READ_INPUT_REGS && mb_addr == INREG_STATUS)
      |=> (mb_rsp_data[ST_OVERRUN] == $past(trigger_overrun)
        && mb_rsp_data[ST_OUT3] == $past(discrete_out[2]));
  endproperty
  a_status_bits: assert property (p_status_bits) else $error("status bit placement wrong");

  property p_msg_read;
    @(posedge clk) disable iff (!rst_n)
    (msg_valid && !msg_write && msg_word == MSG_R_STATUS) |=> msg_rdata == $past(status);
  endproperty
  a_msg_read: assert property (p_msg_read) else $error("message status read wrong");
endmodule // reader_bit_bank

/* File: test/plc_master_model.sv */
// far-side controller model: issues modbus and explicit-message requests
`timescale 1ns/1ps
module plc_master_model (
  input wire logic clk,
  output logic mb_valid,
  output logic [7:0] mb_func,
  output logic [15:0] mb_addr,
  output logic [15:0] mb_wdata,
  output logic msg_valid,
  output logic msg_write,
  output logic [7:0] msg_word,
  output logic [15:0] msg_wdata
);
  initial begin
    mb_valid = 1'b0;
    mb_func = 8'h00;
    mb_addr = 16'h0000;
    mb_wdata = 16'h0000;
    msg_valid = 1'b0;
    msg_write = 1'b0;
    msg_word = 8'h00;
    msg_wdata = 16'h0000;
  end
  // one request per call; address and data are scrambled once the take edge has passed
  task automatic mb(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    mb_valid <= 1'b1;
    mb_func <= f;
    mb_addr <= a;
    mb_wdata <= d;
    @(posedge clk);
    mb_valid <= 1'b0;
    mb_addr <= ~a;
    mb_wdata <= ~d;
  endtask
  task automatic msg(input logic wr, input logic [7:0] wd, input logic [15:0] d);
    @(posedge clk);
    msg_valid <= 1'b1;
    msg_write <= wr;
    msg_word <= wd;
    msg_wdata <= d;
    @(posedge clk);
    msg_valid <= 1'b0;
    msg_word <= ~wd;
    msg_wdata <= ~d;
  endtask
endmodule // plc_master_model

/* File: test/reader_control_ack_status_bits_test.sv */
// self-checking bench for the reader control, acknowledge and status bank
`timescale 1ns/1ps
module reader_control_ack_status_bits_test;
  import reader_bits_pkg::*;
  localparam int BITS [7] = '{BIT_PRODUCT, BIT_LEARN, BIT_TRIGGER, BIT_WINDOW, BIT_TEXT,
    BIT_MASK, BIT_COMMAND};
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [9:0] core = 10'h001;
  logic [31:0] err_in = 32'h0000_0000;
  logic mb_valid, msg_valid, msg_write, mb_rsp_valid, msg_rsp_valid;
  logic [7:0] mb_func, msg_word, mb_rsp_exception;
  logic [15:0] mb_addr, mb_wdata, msg_wdata, mb_rsp_data, msg_rdata, action_pulse;
  logic [31:0] product_number;
  logic [23:0] mbq [$];
  logic [15:0] msgq [$];
  logic [15:0] actq [$];
  int err_count = 0;
  int num_checks = 0;

  always #20 clk = ~clk;

  plc_master_model i_plc_master_model (.clk(clk), .mb_valid(mb_valid), .mb_func(mb_func),
    .mb_addr(mb_addr), .mb_wdata(mb_wdata), .msg_valid(msg_valid), .msg_write(msg_write),
    .msg_word(msg_word), .msg_wdata(msg_wdata));

  reader_bit_bank i_reader_bit_bank (.clk(clk), .resetn(resetn), .mb_valid(mb_valid),
    .mb_func(mb_func), .mb_addr(mb_addr), .mb_wdata(mb_wdata), .mb_rsp_valid(mb_rsp_valid),
    .mb_rsp_data(mb_rsp_data), .mb_rsp_exception(mb_rsp_exception), .msg_valid(msg_valid),
    .msg_write(msg_write), .msg_word(msg_word), .msg_wdata(msg_wdata),
    .msg_rsp_valid(msg_rsp_valid), .msg_rdata(msg_rdata), .ready(core[0]),
    .verdict_pass(core[1]), .code_decoded(core[2]), .discrete_out(core[5:3]),
    .trigger_overrun(core[6]), .learn_fault(core[7]), .system_fault(core[8]),
    .command_fault(core[9]), .error_code(err_in), .action_pulse(action_pulse),
    .product_number(product_number));

  // =====================
  // checking helpers
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // c holds the core levels; the latch bit is passed in since it is sticky
  function automatic logic [15:0] status_of(input logic [9:0] c, input logic latch);
    return {c[9:6], 4'h0, c[5:3], 1'b0, latch, c[2:0]};
  endfunction

  task automatic mbx(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d,
    input logic [7:0] ex, input logic [15:0] exp);
    mbq.push_back({ex, exp});
    i_plc_master_model.mb(f, a, d);
  endtask

  task automatic msgx(input logic wr, input logic [7:0] wd, input logic [15:0] d,
    input logic [15:0] exp);
    msgq.push_back(exp);
    i_plc_master_model.msg(wr, wd, d);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  // =====================
  // answer monitors
  always @(posedge clk) begin
    logic [23:0] e;
    if (mb_rsp_valid === 1'b1) begin
      e = (mbq.size() > 0) ? mbq.pop_front() : 24'hFFFFFF;
      check("mb exception", {8'h00, e[23:16]}, {8'h00, mb_rsp_exception});
      if (e[23:16] == EXC_NONE) check("mb data", e[15:0], mb_rsp_data);
    end
    if (msg_rsp_valid === 1'b1) begin
      if (msgq.size() == 0) check("msg answer count", 16'h0000, 16'h0001);
      else check("msg data", msgq.pop_front(), msg_rdata);
    end
    if (action_pulse !== 16'h0000) begin
      if (actq.size() == 0) check("action pulse", 16'h0000, action_pulse);
      else check("action pulse", actq.pop_front(), action_pulse);
    end
  end

  initial begin
    idle(20000);
    check("run time", 16'h0000, 16'h0001);
    final_report();
  end

  // =====================
  // main sequence
  initial begin
    logic [15:0] m, w, st;
    logic [9:0] c;
    logic [31:0] p, e32;
    void'($urandom(40118));
    idle(2);
    resetn <= 1'b1;
    idle(4);
    mbx(FC_READ_HOLDING, CONTROL_REQUEST_WORD, 16'h0000, EXC_NONE, CONTROL_RESET);
    mbx(FC_READ_INPUT_REGS, INREG_ACK, 16'h0000, EXC_NONE, 16'h0000);
    for (int i = 0; i < 7; i++) begin
      m = 16'h0001 << BITS[i];
      w = m | (16'($urandom) & ~CONTROL_DEFINED);
      actq.push_back(m);
      if (i[0]) begin
        w = m;
        mbx(FC_WRITE_COIL, COIL_FIRST + 16'(BITS[i]), COIL_ON, EXC_NONE, COIL_ON);
      end else begin
        mbx(FC_WRITE_REG, CONTROL_REQUEST_WORD, w, EXC_NONE, w);
      end
      idle(3);
      mbx(FC_READ_INPUT_REGS, INREG_ACK, 16'h0000, EXC_NONE, m);
      mbx(FC_READ_HOLDING, REQUEST_ACKNOWLEDGE_WORD, 16'h0000, EXC_NONE, m);
      mbx(FC_READ_INPUTS, DIN_ACK_FIRST + 16'(BITS[i]), 16'h0000, EXC_NONE, 16'h0001);
      mbx(FC_READ_HOLDING, CONTROL_REQUEST_WORD, 16'h0000, EXC_NONE, w);
      mbx(FC_WRITE_REG, CONTROL_REQUEST_WORD, 16'h0000, EXC_NONE, 16'h0000);
      idle(3);
      mbx(FC_READ_INPUTS, DIN_ACK_FIRST + 16'(BITS[i]), 16'h0000, EXC_NONE, 16'h0000);
    end
    // refused requests must leave the words untouched
    mbx(8'h10, CONTROL_REQUEST_WORD, 16'h0004, EXC_FUNCTION, 16'h0000);
    mbx(FC_READ_HOLDING, 16'h0005, 16'h0000, EXC_ADDRESS, 16'h0000);
    mbx(FC_WRITE_COIL, COIL_LAST + 16'h0001, COIL_ON, EXC_ADDRESS, 16'h0000);
    mbx(FC_WRITE_COIL, COIL_FIRST, 16'h1234, EXC_VALUE, 16'h0000);
    mbx(FC_WRITE_REG, REQUEST_ACKNOWLEDGE_WORD, 16'hFFFF, EXC_ADDRESS, 16'h0000);
    mbx(FC_READ_INPUTS, DIN_LAST + 16'h0001, 16'h0000, EXC_ADDRESS, 16'h0000);
    idle(3);
    mbx(FC_READ_HOLDING, CONTROL_REQUEST_WORD, 16'h0000, EXC_NONE, 16'h0000);
    mbx(FC_READ_INPUT_REGS, INREG_ACK, 16'h0000, EXC_NONE, 16'h0000);
    // ready drops: the latch must hold until a trigger clears it
    c = {9'($urandom), 1'b0};
    core <= c;
    idle(2);
    st = status_of(c, 1'b1);
    mbx(FC_READ_INPUT_REGS, INREG_STATUS, 16'h0000, EXC_NONE, st);
    mbx(FC_READ_HOLDING, READER_STATUS_WORD, 16'h0000, EXC_NONE, st);
    for (int k = 0; k < 16; k++) begin
      mbx(FC_READ_INPUTS, DIN_STATUS_FIRST + 16'(k), 16'h0000, EXC_NONE, {15'h0, st[k]});
    end
    p = $urandom;
    e32 = $urandom;
    err_in <= e32;
    msgx(1'b1, MSG_W_PRODUCT_LO, p[15:0], p[15:0]);
    msgx(1'b1, MSG_W_PRODUCT_HI, p[31:16], p[31:16]);
    actq.push_back(16'h0004);
    msgx(1'b1, MSG_W_CONTROL, 16'h0004, 16'h0004);
    idle(3);
    check("product lo", p[15:0], product_number[15:0]);
    check("product hi", p[31:16], product_number[31:16]);
    msgx(1'b0, MSG_R_ACK, 16'h0000, 16'h0004);
    msgx(1'b0, MSG_R_STATUS, 16'h0000, status_of(c, 1'b0));
    msgx(1'b0, MSG_R_ERROR_LO, 16'h0000, e32[15:0]);
    msgx(1'b0, MSG_R_ERROR_HI, 16'h0000, e32[31:16]);
    msgx(1'b0, 8'h09, 16'h0000, 16'h0000);
    msgx(1'b1, MSG_W_CONTROL, 16'h0000, 16'h0000);
    for (int t = 0; t < 50 && mbq.size() + msgq.size() + actq.size() > 0; t++) begin
      @(posedge clk);
    end
    check("pending answers", 16'h0000, 16'(mbq.size() + msgq.size() + actq.size()));
    final_report();
  end
endmodule // reader_control_ack_status_bits_test
